// >>> bench/file_mem_model.sv
// Data memory file model that answers reads in the same cycle
`timescale 1ns/1ps
module file_mem_model (
   input  wire logic       clk,
   input  wire logic [6:0] raddr,
   input  wire logic       we,
   input  wire logic [6:0] waddr,
   input  wire logic [7:0] wdata,
   output logic      [7:0] rdata
);
   logic [7:0] mem [0:127];
   // Combinational read; the datapath samples it in the cycle it asks
   assign rdata = mem[raddr];
   always @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end
endmodule

// >>> bench/tb_top.sv
// Self-checking bench for the file-register ALU datapath
`timescale 1ns/1ps
`include "file_reg_alu_defines.svh"
module tb_top;
   logic                      clk = 1'b0;
   logic                      rst_n = 1'b0;
   logic                      exec = 1'b0;
   logic                      dest_sel = 1'b0;
   logic                      reg_wr = 1'b0;
   logic                      reg_rd = 1'b0;
   file_reg_alu_pkg::alu_op_t op = file_reg_alu_pkg::op_none;
   logic [6:0]                file_addr = 7'h00;
   logic [7:0]                literal = 8'h00;
   logic [7:0]                reg_wdata = 8'h00;
   logic [1:0]                reg_addr = 2'h0;
   logic [6:0]                file_raddr, file_waddr;
   logic [7:0]                file_rdata, file_wdata, acc, reg_rdata;
   logic                      file_we, zero_flag, carry_flag, skip_nop, exec_ready;
   int                        errors = 0;
   int                        comparisons = 0;
   int                        cycles = 0;

   file_reg_alu_ops i_file_reg_alu_ops (.clk(clk), .rst_n(rst_n), .exec(exec), .op(op),
      .dest_sel(dest_sel), .file_addr(file_addr), .file_rdata(file_rdata), .literal(literal),
      .file_raddr(file_raddr), .file_we(file_we), .file_waddr(file_waddr),
      .file_wdata(file_wdata), .acc(acc), .zero_flag(zero_flag), .carry_flag(carry_flag),
      .skip_nop(skip_nop), .exec_ready(exec_ready), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   file_mem_model i_file_mem_model (.clk(clk), .raddr(file_raddr), .we(file_we),
      .waddr(file_waddr), .wdata(file_wdata), .rdata(file_rdata));

   always #20 clk = ~clk;

   task automatic finish_test();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Ceiling well above the roughly 30 cycles the tests need
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         errors++;
         finish_test();
      end
   end

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One instruction, taken at the next edge; results checked in the cycle after
   task automatic run(input file_reg_alu_pkg::alu_op_t o, input logic d, input logic [6:0] a,
                      input logic [7:0] lit, input logic [7:0] e_acc, input logic e_z,
                      input logic e_c, input logic e_we, input logic [7:0] e_wd,
                      input logic e_skip);
      op <= o;
      dest_sel <= d;
      file_addr <= a;
      literal <= lit;
      exec <= 1'b1;
      @(posedge clk);
      exec <= 1'b0;
      #1;
      chk("acc", e_acc, acc);
      chk("zero_flag", 8'(e_z), 8'(zero_flag));
      chk("carry_flag", 8'(e_c), 8'(carry_flag));
      chk("file_we", 8'(e_we), 8'(file_we));
      if (e_we) begin
         chk("file_wdata", e_wd, file_wdata);
         chk("file_waddr", 8'(a), 8'(file_waddr));
      end
      chk("skip_nop", 8'(e_skip), 8'(skip_nop));
      chk("exec_ready", 8'(!e_skip), 8'(exec_ready));
   endtask

   task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask

   task automatic reg_read(input logic [1:0] a, input logic [7:0] e, input string what);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(what, e, reg_rdata);
   endtask

   task automatic t_increment();
      run(file_reg_alu_pkg::increment_file_op, 1'b1, 7'h10, 8'h00,
          8'h00, 0, 0, 1, 8'h06, 0);
      run(file_reg_alu_pkg::increment_file_op, 1'b0, 7'h7F, 8'h00,
          8'h00, 1, 0, 0, 8'h00, 0);
      run(file_reg_alu_pkg::increment_file_op, 1'b0, 7'h10, 8'h00,
          8'h07, 0, 0, 0, 8'h00, 0);
      $display("test increment done");
   endtask

   task automatic t_skip();
      // Zero flag is 0 here, so a change by the skip would show
      run(file_reg_alu_pkg::increment_skip_zero_op, 1'b0, 7'h7F, 8'h00,
          8'h00, 0, 0, 0, 8'h00, 1);
      // Offered in the nop slot: must be dropped
      run(file_reg_alu_pkg::or_literal_op, 1'b0, 7'h00, 8'hFF,
          8'h00, 0, 0, 0, 8'h00, 0);
      run(file_reg_alu_pkg::increment_skip_zero_op, 1'b1, 7'h10, 8'h00,
          8'h00, 0, 0, 1, 8'h07, 0);
      $display("test skip done");
   endtask

   task automatic t_or();
      run(file_reg_alu_pkg::or_literal_op, 1'b1, 7'h00, 8'h00,
          8'h00, 1, 0, 0, 8'h00, 0);
      run(file_reg_alu_pkg::or_literal_op, 1'b1, 7'h00, 8'hA5,
          8'hA5, 0, 0, 0, 8'h00, 0);
      run(file_reg_alu_pkg::or_file_op, 1'b1, 7'h00, 8'h00,
          8'hA5, 0, 0, 1, 8'hFF, 0);
      $display("test or done");
   endtask

   task automatic t_shift();
      run(file_reg_alu_pkg::shift_left_logical_op, 1'b0, 7'h20, 8'h00,
          8'h02, 0, 1, 0, 8'h00, 0);
      run(file_reg_alu_pkg::shift_left_logical_op, 1'b1, 7'h21, 8'h00,
          8'h02, 1, 1, 1, 8'h00, 0);
      run(file_reg_alu_pkg::shift_left_logical_op, 1'b0, 7'h22, 8'h00,
          8'h80, 0, 0, 0, 8'h00, 0);
      $display("test shift done");
   endtask

   task automatic t_move();
      run(file_reg_alu_pkg::move_file_op, 1'b1, 7'h30, 8'h00,
          8'h80, 1, 0, 1, 8'h00, 0);
      run(file_reg_alu_pkg::move_file_op, 1'b0, 7'h31, 8'h00,
          8'h3C, 0, 0, 0, 8'h00, 0);
      $display("test move done");
   endtask

   task automatic t_regs();
      reg_read(`REG_ACC, 8'h3C, "acc reg");
      // Thirteen operations executed so far; the dropped nop-slot one does not count
      reg_read(`REG_COUNT, 8'h0D, "count reg");
      reg_read(`REG_FLAGS, 8'h00, "flags reg");
      reg_write(`REG_FLAGS, 8'h03);
      reg_read(`REG_FLAGS, 8'h03, "flags reg");
      reg_write(`REG_CTRL, 8'h01);
      reg_read(`REG_CTRL, 8'h01, "ctrl reg");
      // Held accumulator: zero still follows the result 3D
      run(file_reg_alu_pkg::or_literal_op, 1'b0, 7'h00, 8'h01,
          8'h3C, 0, 1, 0, 8'h00, 0);
      reg_write(`REG_CTRL, 8'h00);
      reg_write(`REG_ACC, 8'h00);
      run(file_reg_alu_pkg::or_literal_op, 1'b0, 7'h00, 8'h00,
          8'h00, 1, 1, 0, 8'h00, 0);
      $display("test registers done");
   endtask

   initial begin
      for (int i = 0; i < 128; i++) begin
         i_file_mem_model.mem[i] = 8'(i);
      end
      i_file_mem_model.mem[7'h7F] = 8'hFF;
      i_file_mem_model.mem[7'h10] = 8'h05;
      i_file_mem_model.mem[7'h00] = 8'h5A;
      i_file_mem_model.mem[7'h20] = 8'h81;
      i_file_mem_model.mem[7'h21] = 8'h80;
      i_file_mem_model.mem[7'h22] = 8'h40;
      i_file_mem_model.mem[7'h30] = 8'h00;
      i_file_mem_model.mem[7'h31] = 8'h3C;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk("acc after reset", `ACC_RESET, acc);
      chk("flags after reset", 8'h00, {5'h00, skip_nop, carry_flag, zero_flag});
      chk("ready after reset", 8'h01, 8'(exec_ready));
      t_increment();
      t_skip();
      t_or();
      t_shift();
      t_move();
      t_regs();
      finish_test();
   end
endmodule

// >>> common/file_reg_alu_defines.svh
// Constants for the file-register ALU datapath
`ifndef FILE_REG_ALU_DEFINES_SVH
`define FILE_REG_ALU_DEFINES_SVH

`define DATA_W            8
`define ADDR_W            7
`define FILE_ADDR_MAX     7'h7F
`define DEST_ACC          1'h0
`define DEST_FILE         1'h1
`define ACC_RESET         8'h00
`define SHIFT_MSB         7
`define OP_W              3
`define SKIP_CYCLES       2
`define NORMAL_CYCLES     1
`define REG_CTRL          2'h0
`define REG_ACC           2'h1
`define REG_FLAGS         2'h2
`define REG_COUNT         2'h3
`define FLAG_ZERO_BIT     0
`define FLAG_CARRY_BIT    1
`define FLAG_SKIP_BIT     2
`define CTRL_KEEP_BIT     0

`endif

// >>> common/file_reg_alu_pkg.sv
// Types for the file-register ALU datapath
package file_reg_alu_pkg;
   typedef enum logic [2:0] {
      op_none,
      increment_file_op,
      increment_skip_zero_op,
      or_literal_op,
      or_file_op,
      shift_left_logical_op,
      move_file_op
   } alu_op_t;
endpackage

// >>> src/alu_core.sv
// Combinational result and flag generator
`timescale 1ns/1ps
`include "file_reg_alu_defines.svh"
module alu_core #(
   parameter int WIDTH = `DATA_W
) (
   input  wire file_reg_alu_pkg::alu_op_t op,
   input  wire logic [WIDTH-1:0]          acc,
   input  wire logic [WIDTH-1:0]          file_data,
   input  wire logic [WIDTH-1:0]          literal,
   output logic      [WIDTH-1:0]          result,
   output logic                           carry_out,
   output logic                           zero_out,
   output logic                           zero_valid,
   output logic                           carry_valid
);
   initial begin
      if (WIDTH < 2) $error("alu_core: WIDTH too small");
   end

   always_comb begin
      result      = file_data;
      carry_out   = 1'b0;
      zero_valid  = 1'b1;
      carry_valid = 1'b0;
      case (op)
         file_reg_alu_pkg::increment_file_op: begin
            result = file_data + 1'b1;
         end
         file_reg_alu_pkg::increment_skip_zero_op: begin
            result     = file_data + 1'b1;
            zero_valid = 1'b0;
         end
         file_reg_alu_pkg::or_literal_op: begin
            result = acc | literal;
         end
         file_reg_alu_pkg::or_file_op: begin
            result = acc | file_data;
         end
         file_reg_alu_pkg::shift_left_logical_op: begin
            carry_out   = file_data[WIDTH-1];
            result      = {file_data[WIDTH-2:0], 1'b0};
            carry_valid = 1'b1;
         end
         file_reg_alu_pkg::move_file_op: begin
            result = file_data;
         end
         default: begin
            zero_valid = 1'b0;
         end
      endcase
      zero_out = (result == '0);
   end
endmodule

// >>> src/file_reg_alu_ops.sv
// Execution datapath for increment, OR, shift and move instructions
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "file_reg_alu_defines.svh"
module file_reg_alu_ops #(
   parameter int WIDTH  = `DATA_W,
   parameter int AWIDTH = `ADDR_W
) (
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   input  wire logic                          exec,
   input  wire file_reg_alu_pkg::alu_op_t     op,
   input  wire logic                          dest_sel,
   input  wire logic [AWIDTH-1:0]             file_addr,
   input  wire logic [WIDTH-1:0]              file_rdata,
   input  wire logic [WIDTH-1:0]              literal,
   output logic      [AWIDTH-1:0]             file_raddr,
   output logic                               file_we,
   output logic      [AWIDTH-1:0]             file_waddr,
   output logic      [WIDTH-1:0]              file_wdata,
   output logic      [WIDTH-1:0]              acc,
   output logic                               zero_flag,
   output logic                               carry_flag,
   output logic                               skip_nop,
   output logic                               exec_ready,
   input  wire logic [1:0]                    reg_addr,
   input  wire logic [WIDTH-1:0]              reg_wdata,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   output logic      [WIDTH-1:0]              reg_rdata
);
   initial begin
      if (WIDTH != `DATA_W) $error("file_reg_alu_ops: WIDTH must be 8");
      if (AWIDTH != `ADDR_W) $error("file_reg_alu_ops: AWIDTH must be 7");
   end

   logic [WIDTH-1:0] result;
   logic             alu_carry;
   logic             alu_zero;
   logic             zero_valid;
   logic             carry_valid;
   logic             in_skip;
   logic             busy;
   logic             run;
   logic             keep_acc;
   logic [WIDTH-1:0] exec_count;
   logic             dest_file;

   // Read address goes straight through; file data is valid in the same cycle
   assign file_raddr = file_addr;

   alu_core #(
      .WIDTH(WIDTH)
   ) u_core (
      .op          (op),
      .acc         (acc),
      .file_data   (file_rdata),
      .literal     (literal),
      .result      (result),
      .carry_out   (alu_carry),
      .zero_out    (alu_zero),
      .zero_valid  (zero_valid),
      .carry_valid (carry_valid)
   );

   skip_ctrl u_skip (
      .clk      (clk),
      .rst_n    (rst_n),
      .exec     (run),
      .skip_req (op == file_reg_alu_pkg::increment_skip_zero_op && alu_zero),
      .in_skip  (in_skip),
      .busy     (busy)
   );

   // Instruction in the nop slot is discarded, not executed
   assign run        = exec && !in_skip;
   assign exec_ready = !busy;
   assign skip_nop   = in_skip;

   // Literal OR always targets the accumulator
   assign dest_file = (op != file_reg_alu_pkg::or_literal_op) && (dest_sel == `DEST_FILE);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         acc <= `ACC_RESET;
      end else if (reg_wr && reg_addr == `REG_ACC) begin
         acc <= reg_wdata;
      end else if (run && op != file_reg_alu_pkg::op_none && !dest_file && !keep_acc) begin
         acc <= result;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         file_we    <= 1'b0;
         file_waddr <= '0;
         file_wdata <= '0;
      end else begin
         file_we <= run && op != file_reg_alu_pkg::op_none && dest_file;
         if (run && dest_file) begin
            file_waddr <= file_addr;
            file_wdata <= result;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         zero_flag <= 1'b0;
      end else if (reg_wr && reg_addr == `REG_FLAGS) begin
         zero_flag <= reg_wdata[`FLAG_ZERO_BIT];
      end else if (run && zero_valid) begin
         zero_flag <= alu_zero;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         carry_flag <= 1'b0;
      end else if (reg_wr && reg_addr == `REG_FLAGS) begin
         carry_flag <= reg_wdata[`FLAG_CARRY_BIT];
      end else if (run && carry_valid) begin
         carry_flag <= alu_carry;
      end
   end

   // Control: a set keep bit stops instructions updating the accumulator; a REG_ACC write still loads it (debug hold)
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         keep_acc <= 1'b0;
      end else if (reg_wr && reg_addr == `REG_CTRL) begin
         keep_acc <= reg_wdata[`CTRL_KEEP_BIT];
      end
   end

   // Wraps silently; only a coarse activity indicator
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         exec_count <= '0;
      end else if (run && op != file_reg_alu_pkg::op_none) begin
         exec_count <= exec_count + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            `REG_CTRL:  reg_rdata <= {{(WIDTH-1){1'b0}}, keep_acc};
            `REG_ACC:   reg_rdata <= acc;
            `REG_FLAGS: reg_rdata <= {{(WIDTH-3){1'b0}}, in_skip, carry_flag, zero_flag};
            `REG_COUNT: reg_rdata <= exec_count;
            default:    reg_rdata <= '0;
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end

   sequence s_skip_issue;
      exec && !in_skip && op == file_reg_alu_pkg::increment_skip_zero_op && alu_zero;
   endsequence

   a_skip_inserts_nop: assert property (@(posedge clk) disable iff (!rst_n)
      s_skip_issue |=> in_skip ##1 !in_skip)
      else $error("skip did not insert one nop cycle");

   a_noskip_no_nop: assert property (@(posedge clk) disable iff (!rst_n)
      exec && !in_skip && op == file_reg_alu_pkg::increment_skip_zero_op && !alu_zero
      |=> !in_skip)
      else $error("nop inserted on nonzero result");

   a_skip_keeps_flags: assert property (@(posedge clk) disable iff (!rst_n)
      run && op == file_reg_alu_pkg::increment_skip_zero_op && !reg_wr
      |=> $stable(zero_flag) && $stable(carry_flag))
      else $error("flags changed on increment-and-skip");

   a_inc_result: assert property (@(posedge clk) disable iff (!rst_n)
      run && op == file_reg_alu_pkg::increment_file_op && dest_sel
      |=> file_we && file_wdata == WIDTH'($past(file_rdata) + 1'b1))
      else $error("increment write-back wrong");

   a_or_literal_acc: assert property (@(posedge clk) disable iff (!rst_n)
      run && op == file_reg_alu_pkg::or_literal_op && !keep_acc && !reg_wr
      |=> acc == ($past(acc) | $past(literal)) && !file_we)
      else $error("literal OR result wrong");

   a_or_file_zero: assert property (@(posedge clk) disable iff (!rst_n)
      run && op == file_reg_alu_pkg::or_file_op && !reg_wr
      |=> zero_flag == (($past(acc) | $past(file_rdata)) == '0))
      else $error("OR-file zero flag wrong");

   a_shift_carry: assert property (@(posedge clk) disable iff (!rst_n)
      run && op == file_reg_alu_pkg::shift_left_logical_op && !reg_wr
      |=> carry_flag == $past(file_rdata[`SHIFT_MSB]))
      else $error("shift carry wrong");

   a_shift_lsb_zero: assert property (@(posedge clk) disable iff (!rst_n)
      run && op == file_reg_alu_pkg::shift_left_logical_op && dest_sel
      |=> file_wdata[0] == 1'b0 && file_wdata[WIDTH-1:1] == $past(file_rdata[WIDTH-2:0]))
      else $error("shift result wrong");

   a_move_zero_test: assert property (@(posedge clk) disable iff (!rst_n)
      run && op == file_reg_alu_pkg::move_file_op && dest_sel && !reg_wr
      |=> zero_flag == ($past(file_rdata) == '0) && file_wdata == $past(file_rdata))
      else $error("move write-back or zero wrong");

   a_keep_holds_acc: assert property (@(posedge clk) disable iff (!rst_n)
      keep_acc && !(reg_wr && reg_addr == `REG_ACC) |=> $stable(acc))
      else $error("accumulator changed while held");

   a_nop_slot_idle: assert property (@(posedge clk) disable iff (!rst_n)
      in_skip |=> !file_we)
      else $error("write issued from the nop slot");

   a_count_step: assert property (@(posedge clk) disable iff (!rst_n)
      run && op != file_reg_alu_pkg::op_none
      |=> exec_count == WIDTH'($past(exec_count) + 1))
      else $error("operation counter did not step");

   a_rdata_idle_zero: assert property (@(posedge clk) disable iff (!rst_n)
      !reg_rd |=> reg_rdata == '0)
      else $error("read data not cleared outside read cycle");

   a_single_cycle: assert property (@(posedge clk) disable iff (!rst_n)
      run && op != file_reg_alu_pkg::increment_skip_zero_op |=> exec_ready)
      else $error("operation took more than one cycle");
endmodule

// >>> src/skip_ctrl.sv
// Skip-cycle sequencer for increment-and-skip
`timescale 1ns/1ps
module skip_ctrl (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic exec,
   input  wire logic skip_req,
   output logic      in_skip,
   output logic      busy
);
   typedef enum {st_run, st_nop} skip_state_t;
   skip_state_t state;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= st_run;
      end else begin
         case (state)
            st_run:  state <= (exec && skip_req) ? st_nop : st_run;
            st_nop:  state <= st_run;
            default: state <= st_run;
         endcase
      end
   end

   assign in_skip = (state == st_nop);
   assign busy    = in_skip;
endmodule
